// ### bench/dca_checker.sv
// Purpose: Wire checks on the command/address bus between the two ends
// Assumes: One clock; reset synchronous and active low
// Notes: Parity enable is not visible here, so a parity fault is never required to raise alert
`timescale 1ns/1ps
module dca_checker
    import dca_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic cs_n,
    input wire logic act_n,
    input wire logic [1:0] bg,
    input wire logic [1:0] ba,
    input wire logic [DCA_ADDR_W-1:0] addr,
    input wire logic par,
    input wire logic alert_n
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    wire even_w = ^{act_n, bg, ba, addr};
    // Ten low cycles, split to keep repetition short
    sequence s_rec;
        !alert_n [*8] ##1 !alert_n [*2];
    endsequence
    property p_rst_idle;
        $rose(RST_B_I) |-> alert_n && cs_n && act_n;
    endproperty
    property p_desel_nop;
        cs_n |-> act_n && addr[DCA_A_RAS:DCA_A_WE] == DCA_PIN_NOP;
    endproperty
    property p_alert_cause;
        $fell(alert_n) |-> $past(!cs_n) && $past(par) != $past(even_w);
    endproperty
    property p_alert_len;
        $fell(alert_n) |-> s_rec ##1 alert_n;
    endproperty
    property p_hold_off;
        !alert_n && !$fell(alert_n) |-> cs_n;
    endproperty
    property p_good_par;
        !cs_n && par == even_w && alert_n |=> alert_n;
    endproperty
    property p_desel_quiet;
        cs_n && alert_n |=> alert_n;
    endproperty
    property p_rearm;
        $rose(alert_n) |=> alert_n;
    endproperty
    property p_par_form;
        !cs_n |-> par == even_w || !par;
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("bus not idle after reset");
    a_desel_nop: assert property (p_desel_nop) else $error("deselect without nop pins");
    a_alert_cause: assert property (p_alert_cause) else $error("alert without parity fault");
    a_alert_len: assert property (p_alert_len) else $error("alert length wrong");
    a_hold_off: assert property (p_hold_off) else $error("command during recovery");
    a_good_par: assert property (p_good_par) else $error("alert on good parity");
    a_desel_quiet: assert property (p_desel_quiet) else $error("alert on deselect");
    a_rearm: assert property (p_rearm) else $error("alert refired at once");
    a_par_form: assert property (p_par_form) else $error("parity bit not even");
endmodule

// ### bench/tb.sv
// Purpose: Self-checking bench joining host and device ends
// Assumes: 20 MHz clock; reset held two cycles
// Notes: Parity fault made by turning host parity off while device checks it
`timescale 1ns/1ps
module tb import dca_pkg::*;;
    logic CLK_I = 1'h0;
    logic RST_B_I = 1'h0;
    logic rv = 1'h0;
    dca_cmd_t rc = DCA_NOP;
    logic [1:0] rg = 2'h0;
    logic [1:0] rb = 2'h0;
    logic [DCA_ADDR_W-1:0] ra = 18'h0;
    logic rap = 1'h0;
    logic rch = 1'h0;
    logic pen = 1'h1;
    logic cfg = 1'h0;
    logic ready, alert, cv, ap, allb, chop, paren, parerr, bus_p;
    dca_cmd_t cmd;
    logic [3:0] bank;
    logic [DCA_ADDR_W-1:0] row, mrop, bus_a;
    logic [9:0] col;
    logic [2:0] mrsel;
    int fails = 0;
    int comparisons = 0;
    int n;
    always #25 CLK_I = ~CLK_I;
    dca_ca_if ca_if();
    dca_host dca_host_inst(.CLK_I(CLK_I), .RST_B_I(RST_B_I), .CA(ca_if.host), .REQ_VALID_I(rv),
        .REQ_READY_O(ready), .REQ_CMD_I(rc), .REQ_BG_I(rg), .REQ_BA_I(rb), .REQ_ADDR_I(ra),
        .REQ_AP_I(rap), .REQ_CHOP_I(rch), .PAR_EN_I(pen), .ALERT_O(alert));
    dca_dev dca_dev_inst(.CLK_I(CLK_I), .RST_B_I(RST_B_I), .CA(ca_if.dev), .CFG_X4_16G_I(cfg),
        .CMD_VALID_O(cv), .CMD_O(cmd), .BANK_O(bank), .ROW_O(row), .COL_O(col), .AP_O(ap),
        .ALL_BANKS_O(allb), .CHOP_O(chop), .MR_SEL_O(mrsel), .MR_OP_O(mrop), .PAR_EN_O(paren),
        .PAR_ERR_O(parerr));
    dca_checker dca_checker_inst(.CLK_I(CLK_I), .RST_B_I(RST_B_I), .cs_n(ca_if.cs_n),
        .act_n(ca_if.act_n), .bg(ca_if.bg), .ba(ca_if.ba), .addr(ca_if.addr), .par(ca_if.par),
        .alert_n(ca_if.alert_n));
    task automatic chk(input bit ok, input string m);
        comparisons++;
        if (!ok) begin
            fails++;
            $display("Error %0t: %s", $time, m);
        end
    endtask
    // Returns with decoded outputs settled; n counts edges waited for ready
    task automatic issue(input dca_cmd_t c, input logic [1:0] g, b, input logic [17:0] a, input logic p, h);
        n = 0;
        rc <= c;
        rg <= g;
        rb <= b;
        ra <= a;
        rap <= p;
        rch <= h;
        rv <= 1'h1;
        do begin
            @(posedge CLK_I);
            n++;
        end while (ready !== 1'h1 && n < 40);
        rv <= 1'h0;
        @(posedge CLK_I);
        bus_a = ca_if.addr;
        bus_p = ca_if.par;
        @(posedge CLK_I);
    endtask
    task automatic t_act();
        logic [17:0] a;
        for (int i = 0; i < 32; i++) begin
            a = 18'h2_A5A5 ^ 18'(i);
            cfg <= i[4];
            issue(DCA_ACT, i[3:2], i[1:0], a, 1'h0, 1'h0);
            chk(cv === 1'h1 && cmd === DCA_ACT && bank === i[3:0] && row === {i[4] & a[17], a[16:0]}, "act");
        end
        $display("t_act done");
    endtask
    task automatic t_rdwr();
        dca_cmd_t c;
        for (int i = 0; i < 8; i++) begin
            c = i[2] ? DCA_RD : DCA_WR;
            issue(c, i[1:0], 2'h1, 18'h0_03C5 + 18'(i), i[0], i[1]);
            chk(cmd === c && col === 10'(18'h0_03C5 + 18'(i)) && bank[3:2] === i[1:0], "rd/wr");
            chk(ap === i[0] && bus_a[DCA_A_AP] === i[0], "auto precharge");
            chk(chop === i[1] && bus_a[DCA_A_BC] === !i[1], "burst chop");
            @(posedge CLK_I);
            chk(cv === 1'h0, "deselect taken");
        end
        $display("t_rdwr done");
    endtask
    task automatic t_pre();
        for (int i = 0; i < 2; i++) begin
            issue(DCA_PRE, 2'h3, 2'h2, 18'h0, i[0], 1'h0);
            chk(cmd === DCA_PRE && allb === i[0] && bank === 4'hE, "precharge");
        end
        $display("t_pre done");
    endtask
    task automatic t_misc();
        issue(DCA_REF, 2'h0, 2'h3, 18'h0_1234, 1'h0, 1'h0);
        chk(cv === 1'h1 && cmd === DCA_REF && bus_a[DCA_A_RAS:DCA_A_WE] === DCA_PIN_REF, "refresh");
        issue(DCA_ZQ, 2'h1, 2'h2, 18'h0_0400, 1'h0, 1'h0);
        chk(cv === 1'h1 && cmd === DCA_ZQ && bank === 4'h6, "calibrate");
        issue(DCA_NOP, 2'h0, 2'h0, 18'h0_0000, 1'h0, 1'h0);
        chk(cv === 1'h0 && cmd === DCA_ZQ, "no operation");
        $display("t_misc done");
    endtask
    task automatic t_mrs();
        logic [17:0] a;
        cfg <= 1'h0;
        for (int i = 0; i < 8; i++) begin
            a = 18'h3_C000 | 18'(i);
            issue(DCA_MRS, {1'h1, i[2]}, i[1:0], a, 1'h0, 1'h0);
            chk(cmd === DCA_MRS && mrsel === i[2:0] && mrop === {1'h0, DCA_PIN_MRS, a[13:0]}, "mode set");
        end
        chk(paren === 1'h1, "parity enable");
        $display("t_mrs done");
    endtask
    task automatic t_par();
        pen <= 1'h0;
        issue(DCA_RD, 2'h1, 2'h0, 18'h0, 1'h0, 1'h0);
        chk(parerr === 1'h1 && cv === 1'h0 && alert === 1'h1 && bus_p === 1'h0, "parity fault");
        pen <= 1'h1;
        issue(DCA_WR, 2'h2, 2'h1, 18'h0_0155, 1'h1, 1'h1);
        chk(n === 10 && cv === 1'h1 && cmd === DCA_WR, "recovery wait");
        chk(bus_p === ^{1'h1, 2'h2, 2'h1, bus_a} && alert === 1'h0, "parity sent");
        $display("t_par done");
    endtask
    task automatic finish_test();
        $display("Counts: %0d comparisons, %0d fails", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #100000;
        fails++;
        finish_test();
    end
    initial begin
        repeat (2) @(posedge CLK_I);
        RST_B_I <= 1'h1;
        @(posedge CLK_I);
        chk(cmd === DCA_NOP && paren === 1'h0 && alert === 1'h0 && ca_if.cs_n === 1'h1, "reset");
        t_act();
        t_rdwr();
        t_pre();
        t_misc();
        t_mrs();
        t_par();
        finish_test();
    end
endmodule

// ### rtl/dca_ca_if.sv
// Purpose: Command/address bus between the controller and the memory device
// Assumes: Both ends run on the same clock; all signals change only after its rising edge
// Notes: Address bits 16..14 double as the RAS, CAS and WE command pins

`timescale 1ns/1ps

interface dca_ca_if;
    import dca_pkg::*;

    logic cs_n;
    logic act_n;
    logic [1:0] bg;
    logic [1:0] ba;
    logic [DCA_ADDR_W-1:0] addr;
    logic par;
    logic alert_n;

    modport dev (
        input cs_n,
        input act_n,
        input bg,
        input ba,
        input addr,
        input par,
        output alert_n
    );

    modport host (
        output cs_n,
        output act_n,
        output bg,
        output ba,
        output addr,
        output par,
        input alert_n
    );
endinterface

// ### rtl/dca_dev.sv
// Purpose: Device end: decodes each sampled command into bank, row, column or mode register
// Assumes: Bus inputs are synchronous to CLK_I; the controller keeps its own obligations
// Notes: Decoded results appear one cycle after the sampling edge
//
// Operation
// - Bank group inputs pick the target group
// - Bank group bit 0 helps select mode register
// - Bank inputs pick bank within the group
// - Bank inputs also select the mode register
// - Address is row on activate, column on read/write
// - Mode register op-code taken from address inputs
// - Address bit 17 used only in 16Gb x4; parity here still covers A17 in every configuration
// - A10 on read/write requests auto-precharge
// - A10 on precharge selects all banks
// - A12 low on read/write chops the burst
// - Parity check enabled from mode register 5
// - Parity spans activate, command, bank, address bits
// - Controller presents parity with its command
// - Commands ignored while chip select high
// - Inputs sampled on rising clock edge
// - Activate low turns command pins into address
// - Parity error holds alert low through recovery

`timescale 1ns/1ps

module dca_dev
    import dca_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_B_I,
    dca_ca_if.dev CA,
    input wire logic CFG_X4_16G_I,
    output logic CMD_VALID_O,
    output dca_cmd_t CMD_O,
    output logic [DCA_BANK_W-1:0] BANK_O,
    output logic [DCA_ADDR_W-1:0] ROW_O,
    output logic [DCA_COL_W-1:0] COL_O,
    output logic AP_O,
    output logic ALL_BANKS_O,
    output logic CHOP_O,
    output logic [DCA_MR_W-1:0] MR_SEL_O,
    output logic [DCA_ADDR_W-1:0] MR_OP_O,
    output logic PAR_EN_O,
    output logic PAR_ERR_O
);

    typedef enum logic [1:0] {
        DCA_ST_OK = 2'h0,
        DCA_ST_REC = 2'h1
    } dca_alert_st_t;

    dca_alert_st_t st_q;
    dca_alert_st_t st_d;
    logic [3:0] rec_cnt_q;
    logic [3:0] rec_cnt_d;
    logic alert_n_q;
    logic par_en_q;
    logic par_err_q;
    logic cmd_valid_q;
    dca_cmd_t cmd_q;
    logic [DCA_BANK_W-1:0] bank_q;
    logic [DCA_ADDR_W-1:0] row_q;
    logic [DCA_COL_W-1:0] col_q;
    logic ap_q;
    logic all_banks_q;
    logic chop_q;
    logic [DCA_MR_W-1:0] mr_sel_q;
    logic [DCA_ADDR_W-1:0] mr_op_q;

    wire [DCA_ADDR_W-1:0] addr_eff;
    wire selected;
    wire dca_cmd_t cmd_w;
    wire par_bad;
    wire par_err_w;
    wire take;
    wire is_rw;
    wire [DCA_MR_W-1:0] mr_sel_w;
    wire [DCA_BANK_W-1:0] bank_w;
    wire par_en_wr;

    // Upper address bit reads as zero unless the part is a 16Gb x4
    assign addr_eff = CFG_X4_16G_I ? CA.addr : {1'h0, CA.addr[DCA_A_TOP-1:0]};

    // Recovery also masks commands, so a damaged command stream cannot land
    assign selected = !CA.cs_n && (st_q == DCA_ST_OK);

    // Activate low: pins are row bits; high: pins are the command
    assign cmd_w = CA.act_n ? dca_decode(CA.addr[DCA_A_RAS:DCA_A_WE]) : DCA_ACT;

    // Parity uses the raw pins, A17 included whatever the configuration
    assign par_bad = dca_parity(CA.act_n, CA.bg, CA.ba, CA.addr) != CA.par;
    assign par_err_w = selected && par_en_q && par_bad;
    assign take = selected && !par_err_w && (cmd_w != DCA_NOP);
    assign is_rw = (cmd_w == DCA_RD) || (cmd_w == DCA_WR);

    assign mr_sel_w = {CA.bg[0], CA.ba};
    assign bank_w = {CA.bg, CA.ba};
    assign par_en_wr = take && (cmd_w == DCA_MRS) && (mr_sel_w == DCA_MR_PAR);

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            cmd_valid_q <= 1'h0;
            cmd_q <= DCA_NOP;
            bank_q <= 4'h0;
        end else begin
            cmd_valid_q <= take;
            if (take) begin
                cmd_q <= cmd_w;
                bank_q <= bank_w;
            end
        end
    end

    // Row on activate, column on read/write
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            row_q <= 18'h0_0000;
            col_q <= 10'h000;
        end else begin
            if (take && (cmd_w == DCA_ACT)) begin
                row_q <= addr_eff;
            end
            if (take && is_rw) begin
                col_q <= addr_eff[DCA_COL_W-1:0];
            end
        end
    end

    // Qualifier bits carried on A10 and A12
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            ap_q <= 1'h0;
            chop_q <= 1'h0;
            all_banks_q <= 1'h0;
        end else begin
            if (take && is_rw) begin
                ap_q <= CA.addr[DCA_A_AP];
                chop_q <= !CA.addr[DCA_A_BC];
            end
            if (take && (cmd_w == DCA_PRE)) begin
                all_banks_q <= CA.addr[DCA_A_AP];
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            mr_sel_q <= 3'h0;
            mr_op_q <= 18'h0_0000;
            par_en_q <= 1'h0;
        end else begin
            if (take && (cmd_w == DCA_MRS)) begin
                mr_sel_q <= mr_sel_w;
                mr_op_q <= addr_eff;
            end
            if (par_en_wr) begin
                par_en_q <= CA.addr[DCA_PAR_EN_BIT];
            end
        end
    end

    // Alert sequencing: low for the whole recovery window
    always_comb begin
        st_d = st_q;
        rec_cnt_d = rec_cnt_q;
        unique case (st_q)
            DCA_ST_OK: begin
                if (par_err_w) begin
                    st_d = DCA_ST_REC;
                    rec_cnt_d = DCA_REC_CYC - 4'h1;
                end
            end
            DCA_ST_REC: begin
                if (rec_cnt_q == 4'h0) begin
                    st_d = DCA_ST_OK;
                end else begin
                    rec_cnt_d = rec_cnt_q - 4'h1;
                end
            end
            default: begin
                st_d = DCA_ST_OK;
                rec_cnt_d = 4'h0;
            end
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            st_q <= DCA_ST_OK;
            rec_cnt_q <= 4'h0;
            alert_n_q <= 1'h1;
            par_err_q <= 1'h0;
        end else begin
            st_q <= st_d;
            rec_cnt_q <= rec_cnt_d;
            alert_n_q <= (st_d == DCA_ST_OK);
            par_err_q <= par_err_w;
        end
    end

    assign CA.alert_n = alert_n_q;
    assign CMD_VALID_O = cmd_valid_q;
    assign CMD_O = cmd_q;
    assign BANK_O = bank_q;
    assign ROW_O = row_q;
    assign COL_O = col_q;
    assign AP_O = ap_q;
    assign ALL_BANKS_O = all_banks_q;
    assign CHOP_O = chop_q;
    assign MR_SEL_O = mr_sel_q;
    assign MR_OP_O = mr_op_q;
    assign PAR_EN_O = par_en_q;
    assign PAR_ERR_O = par_err_q;

endmodule

// ### rtl/dca_host.sv
// Purpose: Controller end: turns one user request into one command cycle on the bus
// Assumes: User keeps request fields stable while REQ_VALID_I is high and ready is low
// Notes: Bus is deselected (chip select high, NOP pins) in every cycle without a request

`timescale 1ns/1ps

module dca_host
    import dca_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_B_I,
    dca_ca_if.host CA,
    input wire logic REQ_VALID_I,
    output logic REQ_READY_O,
    input wire dca_cmd_t REQ_CMD_I,
    input wire logic [1:0] REQ_BG_I,
    input wire logic [1:0] REQ_BA_I,
    input wire logic [DCA_ADDR_W-1:0] REQ_ADDR_I,
    input wire logic REQ_AP_I,
    input wire logic REQ_CHOP_I,
    input wire logic PAR_EN_I,
    output logic ALERT_O
);

    logic cs_n_q;
    logic act_n_q;
    logic [1:0] bg_q;
    logic [1:0] ba_q;
    logic [DCA_ADDR_W-1:0] addr_q;
    logic par_q;

    wire fire;
    wire is_act;
    wire is_rw;
    wire [DCA_ADDR_W-1:0] a_cmd;
    wire [DCA_ADDR_W-1:0] a_out;
    wire act_n_w;

    // Held off while the device reports recovery, its commands would be dropped
    assign REQ_READY_O = CA.alert_n;
    assign ALERT_O = !CA.alert_n;
    assign fire = REQ_VALID_I && REQ_READY_O;
    assign is_act = (REQ_CMD_I == DCA_ACT);
    assign is_rw = (REQ_CMD_I == DCA_RD) || (REQ_CMD_I == DCA_WR);
    assign act_n_w = !is_act;

    // Command pins overlay A16..A14 except on activate
    assign a_cmd = {REQ_ADDR_I[DCA_A_TOP], dca_encode(REQ_CMD_I), REQ_ADDR_I[DCA_A_WE-1:0]};

    // Qualifiers overlay A12 and A10
    // Mode set still needs its pin code, so only activate passes the address raw
    assign a_out = is_act ? REQ_ADDR_I :
                   is_rw ? {a_cmd[DCA_ADDR_W-1:DCA_A_BC+1], !REQ_CHOP_I, a_cmd[DCA_A_BC-1:DCA_A_AP+1],
                            REQ_AP_I, a_cmd[DCA_A_AP-1:0]} :
                   (REQ_CMD_I == DCA_PRE) ? {a_cmd[DCA_ADDR_W-1:DCA_A_AP+1], REQ_AP_I,
                                             a_cmd[DCA_A_AP-1:0]} :
                   a_cmd;

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            cs_n_q <= 1'h1;
            act_n_q <= 1'h1;
            bg_q <= 2'h0;
            ba_q <= 2'h0;
            addr_q <= {1'h0, DCA_PIN_NOP, 14'h0000};
            par_q <= 1'h0;
        end else if (fire) begin
            cs_n_q <= 1'h0;
            act_n_q <= act_n_w;
            bg_q <= REQ_BG_I;
            ba_q <= REQ_BA_I;
            addr_q <= a_out;
            par_q <= PAR_EN_I && dca_parity(act_n_w, REQ_BG_I, REQ_BA_I, a_out);
        end else begin
            cs_n_q <= 1'h1;
            act_n_q <= 1'h1;
            addr_q <= {1'h0, DCA_PIN_NOP, 14'h0000};
            par_q <= 1'h0;
        end
    end

    assign CA.cs_n = cs_n_q;
    assign CA.act_n = act_n_q;
    assign CA.bg = bg_q;
    assign CA.ba = ba_q;
    assign CA.addr = addr_q;
    assign CA.par = par_q;

endmodule

// ### rtl/dca_pkg.sv
// Purpose: Shared constants, types and functions for the command/address decode link
// Assumes: One 20 MHz clock drives both ends; command pins are sampled at its rising edge
// Notes: Pin codes are the values of the RAS/CAS/WE pins while the activate input is high

package dca_pkg;

    localparam int DCA_ADDR_W = 18;
    localparam int DCA_COL_W = 10;
    localparam int DCA_BANK_W = 4;
    localparam int DCA_MR_W = 3;

    // Address bit positions with extra meaning
    localparam int DCA_A_AP = 10;
    localparam int DCA_A_BC = 12;
    localparam int DCA_A_WE = 14;
    localparam int DCA_A_RAS = 16;
    localparam int DCA_A_TOP = 17;

    // Mode register that holds the parity enable, and the enable bit in its op-code
    localparam logic [DCA_MR_W-1:0] DCA_MR_PAR = 3'h5;
    localparam int DCA_PAR_EN_BIT = 0;

    // Pin codes on RAS, CAS, WE with the activate input high
    localparam logic [2:0] DCA_PIN_MRS = 3'h0;
    localparam logic [2:0] DCA_PIN_REF = 3'h1;
    localparam logic [2:0] DCA_PIN_PRE = 3'h2;
    localparam logic [2:0] DCA_PIN_RFU = 3'h3;
    localparam logic [2:0] DCA_PIN_WR = 3'h4;
    localparam logic [2:0] DCA_PIN_RD = 3'h5;
    localparam logic [2:0] DCA_PIN_ZQ = 3'h6;
    localparam logic [2:0] DCA_PIN_NOP = 3'h7;

    // Recovery time after a parity error, and its length in clock cycles
    localparam int DCA_CLK_NS = 50;
    localparam int DCA_REC_NS = 500;
    localparam int DCA_REC_CYC_I = (DCA_REC_NS + DCA_CLK_NS - 1) / DCA_CLK_NS;
    localparam logic [3:0] DCA_REC_CYC = 4'(DCA_REC_CYC_I);

    typedef enum logic [2:0] {
        DCA_NOP = 3'h0,
        DCA_ACT = 3'h1,
        DCA_RD = 3'h2,
        DCA_WR = 3'h3,
        DCA_PRE = 3'h4,
        DCA_MRS = 3'h5,
        DCA_REF = 3'h6,
        DCA_ZQ = 3'h7
    } dca_cmd_t;

    // Even parity over every protected pin
    function automatic logic dca_parity(input logic act_n, input logic [1:0] bg,
                                        input logic [1:0] ba, input logic [DCA_ADDR_W-1:0] a);
        return ^{act_n, bg, ba, a};
    endfunction

    function automatic dca_cmd_t dca_decode(input logic [2:0] pins);
        dca_cmd_t c;
        c = DCA_NOP;
        unique case (pins)
            DCA_PIN_MRS: c = DCA_MRS;
            DCA_PIN_REF: c = DCA_REF;
            DCA_PIN_PRE: c = DCA_PRE;
            DCA_PIN_WR: c = DCA_WR;
            DCA_PIN_RD: c = DCA_RD;
            DCA_PIN_ZQ: c = DCA_ZQ;
            DCA_PIN_RFU: c = DCA_NOP;
            DCA_PIN_NOP: c = DCA_NOP;
        endcase
        return c;
    endfunction

    function automatic logic [2:0] dca_encode(input dca_cmd_t c);
        logic [2:0] p;
        p = DCA_PIN_NOP;
        unique case (c)
            DCA_MRS: p = DCA_PIN_MRS;
            DCA_REF: p = DCA_PIN_REF;
            DCA_PRE: p = DCA_PIN_PRE;
            DCA_WR: p = DCA_PIN_WR;
            DCA_RD: p = DCA_PIN_RD;
            DCA_ZQ: p = DCA_PIN_ZQ;
            DCA_ACT: p = DCA_PIN_NOP;
            DCA_NOP: p = DCA_PIN_NOP;
        endcase
        return p;
    endfunction

endpackage
